// ==== rtl/crpm_pkg.sv ====
// crpm_pkg: constants, offsets and types of the clock, reset and power unit
// assumes a 25 MHz system clock and an 8-bit register port
package crpm_pkg;

	// ==================================================
	// clock and timing
	localparam int unsigned CLK_SYS_HZ    = 25_000_000;
	localparam int unsigned CLK_SYS_MHZ   = CLK_SYS_HZ / 1_000_000;
	// stop entry/exit latency with watchdog on a stopped autonomous clock
	localparam int unsigned STOP_LAT_NS   = 160;
	localparam int unsigned STOP_LAT_CYC  =
		(STOP_LAT_NS * CLK_SYS_MHZ + 999) / 1000;
	// least width of the internal reset pulse
	localparam int unsigned RST_HOLD_NS   = 640;
	localparam int unsigned RST_HOLD_CYC  =
		(RST_HOLD_NS * CLK_SYS_MHZ + 999) / 1000;
	// pll figures after reset: vco, post divider, bus clock
	localparam int unsigned VCO_RST_KHZ   = 50_000;
	localparam logic [4:0]  POSTDIV_RST   = 5'h03;
	localparam int unsigned BUS_RST_KHZ   =
		VCO_RST_KHZ / (int'(POSTDIV_RST) + 1) / 2;

	// ==================================================
	// register offsets
	localparam logic [3:0] OFS_CLKSEL  = 4'h0;
	localparam logic [3:0] OFS_OSC     = 4'h1;
	localparam logic [3:0] OFS_STATUS  = 4'h2;
	localparam logic [3:0] OFS_POSTDIV = 4'h3;
	localparam logic [3:0] OFS_TRIM    = 4'h4;
	localparam logic [3:0] OFS_DEBUG   = 4'h5;
	localparam logic [3:0] OFS_CAUSE   = 4'h6;

	// ==================================================
	// clock select register fields
	localparam int unsigned B_PLL_SEL   = 7;
	localparam int unsigned B_PSEUDO_STOP_ENABLE      = 6;
	localparam int unsigned B_STOP_DIS  = 5;
	localparam int unsigned B_WD_HIGH   = 4;
	localparam int unsigned B_PER_PSE   = 3;
	localparam int unsigned B_WD_PSE    = 2;
	localparam int unsigned B_PER_SEL   = 1;
	localparam int unsigned B_WD_LOW    = 0;
	localparam logic [7:0]  CLKSEL_RST  = 8'h80;
	// debug register fields
	localparam int unsigned B_DBG_STOP  = 7;
	localparam int unsigned B_DBG_MAX   = 6;
	localparam logic [7:0]  DEBUG_RST   = 8'h00;
	localparam logic [2:0]  WD_RATE_MAX = 3'h7;

	// ==================================================
	// encodings
	localparam logic [1:0] WD_SRC_IRC  = 2'h0;
	localparam logic [1:0] WD_SRC_OSC  = 2'h1;
	localparam logic [1:0] WD_SRC_ACLK = 2'h2;
	localparam logic [1:0] MODE_PEI    = 2'h0;
	localparam logic [1:0] MODE_PEE    = 2'h1;
	localparam logic [1:0] MODE_PBE    = 2'h2;
	localparam int unsigned NUM_RST_SRC = 6;

	typedef enum logic [2:0] {
		ST_RUN, ST_ENTER, ST_FULL, ST_PSEUDO, ST_EXIT
	} crpm_state_t;

endpackage

// ==== rtl/crpm_rst_if.sv ====
// crpm_rst_if: reset request and cause flags between collector and core
// assumes both ends run on the same system clock
`timescale 1ns/100ps
interface crpm_rst_if;
	logic       rst_req; // stretched system reset request
	logic [5:0] cause;   // sticky cause flags
	logic [5:0] clr;     // write-one-to-clear pulses
	modport collector (output rst_req, output cause, input clr);
	modport core      (input rst_req, input cause, output clr);
endinterface

// ==== rtl/crpm_reset_collect.sv ====
// crpm_reset_collect: gathers reset sources, stretches, keeps causes
// assumes all sources are synchronous levels, active high
`timescale 1ns/100ps
module crpm_reset_collect
	import crpm_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// reset sources
	input  wire logic [crpm_pkg::NUM_RST_SRC-1:0] src,
	// to the core
	crpm_rst_if.collector rif
);
	import crpm_pkg::*;

	// ==================================================
	// state
	typedef struct packed {
		logic [4:0] cnt;   // hold counter
		logic       req;   // request level
		logic [5:0] cause; // sticky flags
	} crpm_col_t;

	crpm_col_t s_q; // registered state
	crpm_col_t s_d; // next state

	// any source holds the request, then it lasts the least width
	always_comb begin
		s_d = s_q;
		if (|src) begin
			s_d.cnt = 5'(RST_HOLD_CYC - 1);
			s_d.req = 1'b1;
		end else if (s_q.cnt != 5'h00) begin
			s_d.cnt = s_q.cnt - 5'h01;
		end else begin
			s_d.req = 1'b0;
		end
		// set wins over clear so no event is lost
		s_d.cause = (s_q.cause & ~rif.clr) | src;
	end

	// register the state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rif.rst_req = s_q.req;
	assign rif.cause   = s_q.cause;

endmodule

// ==== rtl/crpm_top.sv ====
// crpm_top: clock source select, stop/pseudo-stop/debug sequencing
// and system reset collection for the controller core
// assumes synchronous inputs, stop_req and wake_req one-cycle pulses
//
// Function
// R1 - reset starts in pll mode, internal reference
// R2 - reset: 50MHz vco, post divider 3
// R3 - software waits oscillator up and lock
// R4 - software waits oscillator up, then deselects pll
// R5 - pll keeps running in bypass mode
// R6 - wait mode behaves exactly like run
// R7 - stop: pll, rc off, regulator reduced
// R8 - stop gates core, bus, debug clocks
// R9 - pseudo stop only with both enables set
// R10 - full stop disables crystal oscillator
// R11 - full stop, low select: counters halt
// R12 - full stop wake forces default clock selects
// R13 - autonomous watchdog clock stops if disabled
// R14 - latency on stop entry and exit
// R15 - full stop halts periodic counter always
// R16 - pseudo stop counters run from oscillator
// R17 - pseudo stop periodic counter needs enable
// R18 - pseudo stop keeps clock select bits
// R19 - software waits oscillator startup before pseudo
// R20 - debug stops counters, may force maximum timeout
// R21 - system reset from six sources
// R22 - trim loaded from factory value after reset
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
module crpm_top
	import crpm_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_we,
	input  wire logic       reg_re,
	output logic      [7:0] reg_rdata,
	// core events
	input  wire logic       stop_req,
	input  wire logic       wake_req,
	input  wire logic       debug_active,
	// clock source status
	input  wire logic       oscillator_up_flag,
	input  wire logic       pll_lock,
	input  wire logic [7:0] factory_trim,
	// reset sources
	input  wire logic       power_on_reset,
	input  wire logic       low_voltage_reset,
	input  wire logic       illegal_address,
	input  wire logic       watchdog_timeout,
	input  wire logic       clock_monitor_fail,
	input  wire logic       reset_pin_in_n,
	// clock source controls
	output logic            pll_enable,
	output logic            irc_enable,
	output logic            oscillator_run,
	output logic            regulator_reduced_mode,
	output logic            pll_ref_crystal,
	output logic            bus_src_pll,
	output logic      [4:0] post_divider,
	output logic      [7:0] internal_osc_trim,
	// clock gates
	output logic            core_clk_en,
	output logic            bus_clk_en,
	output logic            debug_clk_en,
	// counter clocking
	output logic            watchdog_clk_run,
	output logic      [1:0] watchdog_src,
	output logic            aclk_run,
	output logic      [2:0] watchdog_rate,
	output logic            periodic_clk_run,
	output logic            periodic_src_osc,
	// reset outputs
	output logic            system_reset,
	output logic            reset_pin_out,
	output logic            reset_pin_oe
);
	import crpm_pkg::*;

	// ==================================================
	// state record
	typedef struct packed {
		crpm_state_t st;        // power sequencer
		logic [2:0]  lat;       // latency counter
		logic        pseudo;    // chosen stop kind
		logic [7:0]  clk_ctl;   // clock select register
		logic        osc_en;    // oscillator enable
		logic [4:0]  postdiv;   // pll post divider
		logic [7:0]  trim;      // rc trim value
		logic        trim_pend; // factory load due
		logic [7:0]  dbg;       // debug control
		logic [7:0]  rdata;     // read data
		logic        pll_en;
		logic        irc_en;
		logic        osc_run;
		logic        reg_rpm;
		logic        ref_xtal;
		logic        src_pll;
		logic        core_en;
		logic        bus_en;
		logic        dbg_en;
		logic        wd_run;
		logic [1:0]  wd_src;
		logic        aclk;
		logic [2:0]  wd_rate;
		logic        per_run;
		logic        per_osc;
		logic        sysrst;
		logic        pin_oe;
	} crpm_core_t;

	crpm_core_t s_q; // registered state
	crpm_core_t s_d; // next state

	// reset value of the whole record
	function automatic crpm_core_t rst_val();
		crpm_core_t v;
		v           = '0;
		v.st        = ST_RUN;
		v.clk_ctl   = CLKSEL_RST;   // R1
		v.postdiv   = POSTDIV_RST;  // R2
		v.dbg       = DEBUG_RST;
		v.trim_pend = 1'b1;         // R22
		v.pll_en    = 1'b1;
		v.irc_en    = 1'b1;
		v.src_pll   = 1'b1;
		v.core_en   = 1'b1;
		v.bus_en    = 1'b1;
		v.dbg_en    = 1'b1;
		v.wd_run    = 1'b1;
		v.per_run   = 1'b1;
		return v;
	endfunction

	// ==================================================
	// reset collection
	crpm_rst_if rif (); // link to the collector
	logic [NUM_RST_SRC-1:0] rst_src;

	// own drive of the pin must not be seen as an outside reset
	assign rst_src = {!reset_pin_in_n && !s_q.pin_oe, clock_monitor_fail,
		watchdog_timeout, illegal_address, low_voltage_reset,
		power_on_reset}; // R21

	crpm_reset_collect u_collect (
		.clk_sys (clk_sys),
		.rst     (rst),
		.src     (rst_src),
		.rif     (rif)
	);

	// ==================================================
	// next state
	logic need_lat; // watchdog on a clock that stop will halt
	logic stopped;  // in full or pseudo stop
	logic full;     // in full stop
	logic psd;      // in pseudo stop
	logic dbg_halt; // debug freezes the counters
	logic [1:0] clk_mode;

	always_comb begin
		s_d      = s_q;
		rif.clr  = '0;
		need_lat = s_q.clk_ctl[B_WD_HIGH] && s_q.clk_ctl[B_STOP_DIS];
		// clock mode as seen by software
		if (!s_q.clk_ctl[B_PLL_SEL]) begin
			clk_mode = MODE_PBE;
		end else if (s_q.osc_en) begin
			clk_mode = MODE_PEE;
		end else begin
			clk_mode = MODE_PEI;
		end

		// factory trim comes first so a write the same cycle wins
		if (s_q.trim_pend) begin
			s_d.trim      = factory_trim; // R22
			s_d.trim_pend = 1'b0;
		end

		// read port: data stand one cycle, zero otherwise
		s_d.rdata = 8'h00;
		if (reg_re) begin
			case (reg_addr)
				OFS_CLKSEL:  s_d.rdata = s_q.clk_ctl;
				OFS_OSC:     s_d.rdata = {7'h00, s_q.osc_en};
				OFS_STATUS:  s_d.rdata = {1'b0, clk_mode, s_q.st,
					pll_lock, oscillator_up_flag};
				OFS_POSTDIV: s_d.rdata = {3'h0, s_q.postdiv};
				OFS_TRIM:    s_d.rdata = s_q.trim;
				OFS_DEBUG:   s_d.rdata = s_q.dbg;
				OFS_CAUSE:   s_d.rdata = {2'h0, rif.cause};
				default:     s_d.rdata = 8'h00;
			endcase
		end

		// write port
		if (reg_we) begin
			case (reg_addr)
				OFS_CLKSEL:  s_d.clk_ctl = reg_wdata;
				OFS_OSC:     s_d.osc_en  = reg_wdata[0];
				OFS_POSTDIV: s_d.postdiv = reg_wdata[4:0];
				OFS_TRIM: begin
					s_d.trim      = reg_wdata; // R22
					s_d.trim_pend = 1'b0;
				end
				OFS_DEBUG:   s_d.dbg     = reg_wdata;
				OFS_CAUSE:   rif.clr     = reg_wdata[5:0];
				default: ;  // unmapped: ignored
			endcase
		end

		// power sequencer; wait mode never leaves run
		case (s_q.st)
			ST_RUN: begin // R6
				if (stop_req) begin
					// kind is fixed at entry
					s_d.pseudo = s_q.clk_ctl[B_PSEUDO_STOP_ENABLE] && s_q.osc_en; // R9
					if (need_lat) begin
						s_d.st  = ST_ENTER; // R14
						s_d.lat = 3'(STOP_LAT_CYC - 1);
					end else begin
						s_d.st = s_d.pseudo ? ST_PSEUDO : ST_FULL;
					end
				end
			end
			ST_ENTER: begin // R14
				if (s_q.lat == 3'h0) begin
					s_d.st = s_q.pseudo ? ST_PSEUDO : ST_FULL;
				end else begin
					s_d.lat = s_q.lat - 3'h1;
				end
			end
			ST_FULL, ST_PSEUDO: begin
				if (wake_req) begin
					// pseudo stop leaves the selects alone
					if (s_q.st == ST_FULL) begin // R18
						s_d.clk_ctl[B_PLL_SEL] = 1'b1; // R12
						s_d.clk_ctl[B_WD_LOW]  = 1'b0; // R12
						s_d.clk_ctl[B_PER_SEL] = 1'b0; // R12
					end
					if (need_lat) begin
						s_d.st  = ST_EXIT; // R14
						s_d.lat = 3'(STOP_LAT_CYC - 1);
					end else begin
						s_d.st = ST_RUN;
					end
				end
			end
			ST_EXIT: begin // R14
				if (s_q.lat == 3'h0) begin
					s_d.st = ST_RUN;
				end else begin
					s_d.lat = s_q.lat - 3'h1;
				end
			end
			default: s_d.st = ST_RUN;
		endcase

		// system reset puts all control back to defaults
		if (rif.rst_req) begin
			s_d = rst_val(); // R1
		end

		// ------------------------------------------------
		// outputs from the next state; exit latency keeps the stop on
		full     = s_d.st == ST_FULL || (s_d.st == ST_EXIT && !s_d.pseudo);
		psd      = s_d.st == ST_PSEUDO || (s_d.st == ST_EXIT && s_d.pseudo);
		stopped  = full || psd;
		dbg_halt = debug_active && s_d.dbg[B_DBG_STOP];

		// pll runs in every run mode, bypass included
		s_d.pll_en  = !stopped; // R5 R7
		s_d.irc_en  = !stopped; // R7
		s_d.reg_rpm = stopped;  // R7
		s_d.core_en = !stopped; // R8
		s_d.bus_en  = !stopped; // R8
		s_d.dbg_en  = !stopped; // R8
		s_d.osc_run = s_d.osc_en && !full; // R10
		// crystal becomes reference only once it is up
		s_d.ref_xtal = s_d.osc_en && oscillator_up_flag; // R3
		// never switch to a crystal that is not running yet
		s_d.src_pll = s_d.clk_ctl[B_PLL_SEL] || !oscillator_up_flag; // R4
		s_d.aclk = s_d.clk_ctl[B_WD_HIGH] &&
			!(stopped && s_d.clk_ctl[B_STOP_DIS]); // R13

		// counter clocking per mode
		if (full) begin
			s_d.wd_run  = s_d.aclk; // R11 R13
			s_d.per_run = 1'b0;     // R11 R15
			s_d.per_osc = s_d.clk_ctl[B_PER_SEL];
		end else if (psd) begin
			s_d.per_osc = 1'b1;     // R16
			if (s_d.clk_ctl[B_WD_HIGH]) begin
				s_d.wd_run  = s_d.aclk;                 // R13
				s_d.per_run = s_d.clk_ctl[B_PER_PSE];   // R17
			end else begin
				s_d.wd_run  = s_d.clk_ctl[B_WD_PSE] &&
					s_d.clk_ctl[B_PER_PSE];               // R16
				s_d.per_run = s_d.wd_run;               // R16
			end
		end else begin
			s_d.wd_run  = !dbg_halt; // R20
			s_d.per_run = !dbg_halt; // R20
			s_d.per_osc = s_d.clk_ctl[B_PER_SEL];
		end

		// watchdog clock source
		if (s_d.clk_ctl[B_WD_HIGH]) begin
			s_d.wd_src = WD_SRC_ACLK; // R13
		end else if (psd || s_d.clk_ctl[B_WD_LOW]) begin
			s_d.wd_src = WD_SRC_OSC;  // R16
		end else begin
			s_d.wd_src = WD_SRC_IRC;  // R12
		end

		// debug may push the watchdog to its longest period
		s_d.wd_rate = (debug_active && s_d.dbg[B_DBG_MAX]) ?
			WD_RATE_MAX : s_d.dbg[2:0]; // R20
		s_d.sysrst = rif.rst_req; // R21
		s_d.pin_oe = rif.rst_req; // R21
	end

	// ==================================================
	// register the record
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= rst_val();
		end else begin
			s_q <= s_d;
		end
	end

	// ==================================================
	// outputs, all straight from flops but reset_pin_out, tied low
	assign reg_rdata              = s_q.rdata;
	assign pll_enable             = s_q.pll_en;
	assign irc_enable             = s_q.irc_en;
	assign oscillator_run         = s_q.osc_run;
	assign regulator_reduced_mode = s_q.reg_rpm;
	assign pll_ref_crystal        = s_q.ref_xtal;
	assign bus_src_pll            = s_q.src_pll;
	assign post_divider           = s_q.postdiv;
	assign internal_osc_trim      = s_q.trim;
	assign core_clk_en            = s_q.core_en;
	assign bus_clk_en             = s_q.bus_en;
	assign debug_clk_en           = s_q.dbg_en;
	assign watchdog_clk_run       = s_q.wd_run;
	assign watchdog_src           = s_q.wd_src;
	assign aclk_run               = s_q.aclk;
	assign watchdog_rate          = s_q.wd_rate;
	assign periodic_clk_run       = s_q.per_run;
	assign periodic_src_osc       = s_q.per_osc;
	assign system_reset           = s_q.sysrst;
	assign reset_pin_out          = 1'b0; // open drain: only pulls low
	assign reset_pin_oe           = s_q.pin_oe;

	// ==================================================
	// assertions
	property p_rst_defaults; // R1
		@(posedge clk_sys) disable iff (rst)
		system_reset |-> bus_src_pll && !pll_ref_crystal
			&& s_q.clk_ctl == CLKSEL_RST;
	endproperty
	a_rst_defaults: assert property (p_rst_defaults) // R1
		else $error("reset did not select pll internal mode");

	property p_postdiv; // R2
		@(posedge clk_sys) disable iff (rst)
		$fell(system_reset) |-> post_divider == 5'h03;
	endproperty
	a_postdiv: assert property (p_postdiv) // R2
		else $error("post divider not 3 after reset");

	property p_stop_power; // R7
		@(posedge clk_sys) disable iff (rst)
		(s_q.st == ST_FULL || s_q.st == ST_PSEUDO) |->
			!pll_enable && !irc_enable && regulator_reduced_mode;
	endproperty
	a_stop_power: assert property (p_stop_power) // R7
		else $error("stop left pll, rc or full regulator on");

	property p_stop_gate; // R8
		@(posedge clk_sys) disable iff (rst)
		$rose(s_q.st == ST_FULL || s_q.st == ST_PSEUDO) |->
			!core_clk_en && !bus_clk_en && !debug_clk_en;
	endproperty
	a_stop_gate: assert property (p_stop_gate) // R8
		else $error("clocks not gated in stop");

	property p_pseudo_cond; // R9
		@(posedge clk_sys) disable iff (rst)
		(s_q.st == ST_RUN && stop_req && !need_lat && !rif.rst_req) |=>
			(s_q.st == ST_PSEUDO) == ($past(s_q.clk_ctl[B_PSEUDO_STOP_ENABLE])
			&& $past(s_q.osc_en));
	endproperty
	a_pseudo_cond: assert property (p_pseudo_cond) // R9
		else $error("wrong stop kind chosen");

	property p_full_halt; // R10
		@(posedge clk_sys) disable iff (rst)
		s_q.st == ST_FULL |-> !oscillator_run && !periodic_clk_run
			&& (watchdog_clk_run == aclk_run);
	endproperty
	a_full_halt: assert property (p_full_halt) // R10
		else $error("full stop left oscillator or counters on");

	property p_full_wake; // R12
		@(posedge clk_sys) disable iff (rst)
		($past(s_q.st) == ST_FULL && s_q.st != ST_FULL) |->
			s_q.clk_ctl[B_PLL_SEL] && !s_q.clk_ctl[B_WD_LOW]
			&& !s_q.clk_ctl[B_PER_SEL];
	endproperty
	a_full_wake: assert property (p_full_wake) // R12
		else $error("full stop wake kept custom clock selects");

	property p_latency; // R14
		@(posedge clk_sys) disable iff (rst)
		(s_q.st == ST_RUN && stop_req && need_lat && !rif.rst_req
			&& !(|rst_src)) |=>
			(s_q.st == ST_ENTER && core_clk_en) [*4] ##1
			(s_q.st == ST_FULL || s_q.st == ST_PSEUDO);
	endproperty
	a_latency: assert property (p_latency) // R14
		else $error("stop entry latency wrong");

	property p_debug_freeze; // R20
		@(posedge clk_sys) disable iff (rst)
		(s_q.st == ST_RUN && !stop_req && debug_active
			&& s_q.dbg[B_DBG_STOP] && !rif.rst_req && !reg_we) |=>
			!watchdog_clk_run && !periodic_clk_run;
	endproperty
	a_debug_freeze: assert property (p_debug_freeze) // R20
		else $error("counters ran in debug freeze");

endmodule

// ==== verification/crpm_src_model.sv ====
// crpm_src_model: crystal start-up and pll lock as seen by the unit
// assumes one clock; enables from the unit are registered levels
`timescale 1ns/100ps
module crpm_src_model #(
	parameter int OSC_UP_CYC = 24, // crystal start-up, short for the run
	parameter int LOCK_CYC   = 12  // pll lock time
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// enables from the unit
	input  wire logic oscillator_run,
	input  wire logic pll_enable,
	// status back to the unit
	output logic      oscillator_up_flag,
	output logic      pll_lock
);
	// ==================================================
	// start-up counters
	int osc_cnt_q;  // cycles since crystal enabled
	int lock_cnt_q; // cycles since pll enabled
	// flags drop at once when a source stops, so no stale status
	// survives a full stop
	always_ff @(posedge clk_sys) begin
		if (rst || !oscillator_run) begin
			osc_cnt_q <= 0;
		end else if (osc_cnt_q < OSC_UP_CYC) begin
			osc_cnt_q <= osc_cnt_q + 1;
		end
		if (rst || !pll_enable) begin
			lock_cnt_q <= 0;
		end else if (lock_cnt_q < LOCK_CYC) begin
			lock_cnt_q <= lock_cnt_q + 1;
		end
	end
	assign oscillator_up_flag = (osc_cnt_q >= OSC_UP_CYC);
	assign pll_lock           = (lock_cnt_q >= LOCK_CYC);
endmodule

// ==== verification/test_crpm_top.sv ====
// test_crpm_top: register, stop, debug and reset sequences of the unit
// assumes crpm_src_model stands in for the crystal and pll
`timescale 1ns/100ps
module test_crpm_top;
	import crpm_pkg::*;
	// ==================================================
	// stimulus and observed signals
	logic       clk_sys = 1'b0, rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, internal_osc_trim;
	logic [7:0] factory_trim = 8'h5a; // arbitrary trim pattern
	logic       reg_we = 1'b0, reg_re = 1'b0;
	logic       stop_req = 1'b0, wake_req = 1'b0, debug_active = 1'b0;
	logic [5:0] srcv = 6'h00; // reset sources, cause bit order
	logic       oscillator_up_flag, pll_lock, pll_enable, irc_enable;
	logic       oscillator_run, regulator_reduced_mode, pll_ref_crystal;
	logic       bus_src_pll, core_clk_en, bus_clk_en, debug_clk_en;
	logic       watchdog_clk_run, aclk_run, periodic_clk_run;
	logic       periodic_src_osc, system_reset, reset_pin_out, reset_pin_oe;
	logic [4:0] post_divider;
	logic [1:0] watchdog_src;
	logic [2:0] watchdog_rate;
	int         err_total = 0, checks_done = 0, n;

	// ==================================================
	// design and far side
	crpm_top dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re,
		.reg_rdata, .stop_req, .wake_req, .debug_active,
		.oscillator_up_flag, .pll_lock, .factory_trim,
		.power_on_reset(srcv[0]), .low_voltage_reset(srcv[1]),
		.illegal_address(srcv[2]), .watchdog_timeout(srcv[3]),
		.clock_monitor_fail(srcv[4]), .reset_pin_in_n(~srcv[5]),
		.pll_enable, .irc_enable, .oscillator_run, .regulator_reduced_mode,
		.pll_ref_crystal, .bus_src_pll, .post_divider, .internal_osc_trim,
		.core_clk_en, .bus_clk_en, .debug_clk_en, .watchdog_clk_run,
		.watchdog_src, .aclk_run, .watchdog_rate, .periodic_clk_run,
		.periodic_src_osc, .system_reset, .reset_pin_out, .reset_pin_oe);
	crpm_src_model src (.clk_sys, .rst, .oscillator_run, .pll_enable,
		.oscillator_up_flag, .pll_lock);

	// 25 MHz clock
	always #20 clk_sys = ~clk_sys;

	// ==================================================
	// helpers
	task end_sim;
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// value compare, four-state exact
	task chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one-cycle write strobe
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_we <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask
	// read strobe, data looked at in the following cycle only
	task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask
	// selectable condition for bounded waits
	function logic sig(input int s);
		case (s)
			0: sig = core_clk_en;
			1: sig = system_reset;
			default: sig = oscillator_up_flag & pll_lock;
		endcase
	endfunction
	// counts cycles until the condition holds, gives up at 40
	task wt(input int s, input logic v, output int k);
		k = 1;
		while (sig(s) !== v && k < 40) begin
			@(posedge clk_sys);
			#1 k++;
		end
		// a wait that runs out is a mismatch of its own
		if (sig(s) !== v) begin
			err_total++;
			$display("BAD t=%0t wait got=%h exp=%h", $time, sig(s), v);
		end
	endtask
	// stop (w=0) or wake (w=1) pulse, cycles until clocks follow
	task ev(input logic w, output int k);
		@(posedge clk_sys);
		if (w) begin
			wake_req <= 1'b1;
		end else begin
			stop_req <= 1'b1;
		end
		@(posedge clk_sys);
		wake_req <= 1'b0;
		stop_req <= 1'b0;
		#1 wt(0, w, k);
	endtask

	// ==================================================
	// hang guard, far beyond the expected run
	initial begin
		#400000;
		err_total++;
		end_sim;
	end

	// ==================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk({bus_src_pll, pll_enable, irc_enable}, 8'h07);
		chk(post_divider, POSTDIV_RST);
		chk(internal_osc_trim, factory_trim);
		rd(OFS_CLKSEL, 8'hff, CLKSEL_RST);
		rd(OFS_STATUS, 8'h7c, 8'h00);
		rd(4'hf, 8'hff, 8'h00);
		wr(OFS_TRIM, 8'h33);
		chk(internal_osc_trim, 8'h33);
		// external reference, then bypass
		wr(OFS_OSC, 8'h01);
		wt(2, 1'b1, n);
		// crystal reference follows the up flag one edge later
		@(posedge clk_sys);
		#1 chk(pll_ref_crystal, 8'h01);
		rd(OFS_STATUS, 8'h60, 8'h20);
		wr(OFS_CLKSEL, 8'h00);
		chk({bus_src_pll, pll_enable}, 8'h01);
		rd(OFS_STATUS, 8'h60, 8'h40);
		// pseudo stop, counters on the crystal
		wr(OFS_CLKSEL, 8'h4e);
		ev(1'b0, n);
		chk(8'(n), 8'h01);
		chk({core_clk_en, bus_clk_en, debug_clk_en}, 8'h00);
		chk({pll_enable, irc_enable, regulator_reduced_mode}, 8'h01);
		chk({oscillator_run, watchdog_clk_run, periodic_clk_run}, 8'h07);
		chk({periodic_src_osc, watchdog_src}, 8'h05);
		ev(1'b1, n);
		rd(OFS_CLKSEL, 8'hff, 8'h4e);
		// full stop, then default selects after wake
		wr(OFS_CLKSEL, 8'h03);
		ev(1'b0, n);
		chk({oscillator_run, watchdog_clk_run, periodic_clk_run}, 8'h00);
		chk({pll_enable, irc_enable, regulator_reduced_mode}, 8'h01);
		ev(1'b1, n);
		rd(OFS_CLKSEL, 8'hff, CLKSEL_RST);
		chk({watchdog_src, periodic_src_osc}, 8'h00);
		// pseudo stop asked with crystal off falls back to full stop
		wr(OFS_OSC, 8'h00);
		wr(OFS_CLKSEL, 8'hcc);
		ev(1'b0, n);
		chk(watchdog_clk_run, 8'h00);
		ev(1'b1, n);
		wr(OFS_OSC, 8'h01);
		wt(2, 1'b1, n);
		// autonomous watchdog clock stopped in stop: latency both ways
		wr(OFS_CLKSEL, 8'hb0);
		chk(watchdog_src, WD_SRC_ACLK);
		ev(1'b0, n);
		chk(8'(n), 8'(1 + STOP_LAT_CYC));
		chk({aclk_run, periodic_clk_run}, 8'h00);
		ev(1'b1, n);
		chk(8'(n), 8'(1 + STOP_LAT_CYC));
		// autonomous clock kept running: no latency
		wr(OFS_CLKSEL, 8'h90);
		ev(1'b0, n);
		chk(8'(n), 8'h01);
		chk({aclk_run, periodic_clk_run}, 8'h02);
		ev(1'b1, n);
		// crystal restarts after full stop: let it settle first
		wt(2, 1'b1, n);
		// periodic counter in pseudo stop follows its own enable
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CLKSEL, 8'hd0 | 8'(i << 3));
			ev(1'b0, n);
			chk(periodic_clk_run, 8'(i));
			ev(1'b1, n);
		end
		// debug freeze
		wr(OFS_DEBUG, 8'hc0);
		@(posedge clk_sys);
		debug_active <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 chk({watchdog_clk_run, periodic_clk_run}, 8'h00);
		chk(watchdog_rate, WD_RATE_MAX);
		wr(OFS_DEBUG, 8'h02);
		chk({watchdog_clk_run, periodic_clk_run, watchdog_rate}, 8'h1a);
		@(posedge clk_sys);
		debug_active <= 1'b0;
		// every reset source, cause kept, controls back to defaults
		wr(OFS_CAUSE, 8'h3f);
		for (int i = 0; i < 6; i++) begin
			wr(OFS_CLKSEL, 8'h00);
			@(posedge clk_sys);
			srcv <= 6'(1 << i);
			#1 wt(1, 1'b1, n);
			chk(8'(n), 8'h03);
			chk({reset_pin_oe, reset_pin_out}, 8'h02);
			@(posedge clk_sys);
			srcv <= 6'h00;
			#1 wt(1, 1'b0, n);
			chk(system_reset, 8'h00);
			rd(OFS_CAUSE, 8'hff, 8'(1 << i));
			rd(OFS_CLKSEL, 8'hff, CLKSEL_RST);
			wr(OFS_CAUSE, 8'h3f);
		end
		end_sim;
	end
endmodule
